//--- stall_detector_consts.svh
// Offsets, field positions, reset values and counts for the stall detector control
`ifndef STALL_DETECTOR_CONSTS_SVH
`define STALL_DETECTOR_CONSTS_SVH
`define ADDR_COUNTER_CONTROL 8'h01
`define ADDR_STALL_DETECT_CONTROL 8'h02
`define ADDR_FLAGS 8'h03
`define ADDR_COUNT_HIGH 8'h04
`define ADDR_COUNT_LOW 8'h05
`define ADDR_INTEGRATE 8'h08
`define BIT_UNDERFLOW_IRQ_ENABLE 7
`define BIT_RELOAD_MODE 6
`define BIT_READ_LOAD_SELECT 5
`define BIT_PRESCALER 4
`define BIT_FORCE_LOAD 3
`define BIT_COUNTER_ENABLE 2
`define BIT_ACC_OVERFLOW_IRQ_ENABLE 0
`define BIT_RETURN_TO_ZERO_ENABLE 7
`define BIT_CONVERTER_POWER_UP 6
`define BIT_WAIT_MODE_DISABLE 5
`define BIT_UNDERFLOW_FLAG 7
`define BIT_ACC_OVERFLOW_FLAG 0
`define BIT_INTEGRATE_CONTROL 7
`define COUNT_PRESET 16'hFFFF
`define COUNT_ZERO 16'h0000
`define BYTE_ZERO 8'h00
`define PRESCALE_SHORT 10'h03F
`define PRESCALE_LONG 10'h1FF
`define SAMPLE_BASE 7'h07
`define DIV_ZERO 10'h000
`define SAMPLE_ZERO 7'h00
`define CC_STORE_MASK 8'hF5
`define SC_STORE_MASK 8'hE3
`define COUNT_ONE 16'h0001
`define HIGH_BYTE 15:8
`define LOW_BYTE 7:0
`define SAMPLE_SELECT 1:0
`endif

//--- stall_detector_pkg.sv
// Types shared by the stall detector control
package stall_detector_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  typedef struct packed {
    logic owned;
    logic recirc_low;
  } coil_ctl_t;
endpackage

//--- stall_detector_control.sv
// Stall detector control: modulus down-counter and detector control registers
`timescale 1ns/10ps
`default_nettype none
`include "stall_detector_consts.svh"

module stall_detector_control (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire stall_detector_pkg::bus_req_t bus,
  output logic [7:0] rdata,
  // System wait and accumulator overflow event
  input wire logic wait_mode,
  input wire logic acc_overflow_event,
  // Outputs to analog and coils
  output logic irq,
  output logic converter_power,
  output logic converter_reset,
  output stall_detector_pkg::coil_ctl_t coil_ctl,
  output logic counter_tick,
  output logic sample_tick,
  output logic [1:0] sample_rate_active
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] counter_control;
  logic [7:0] stall_detect_control;
  logic integrate_control;
  logic underflow_flag;
  logic acc_overflow_flag;
  logic [15:0] count;
  logic [15:0] load_value;
  logic prescale_active;
  logic [9:0] prescale_div;
  logic [6:0] sample_div;
  logic wait_s1;
  logic wait_s2;
  logic ovf_s1;
  logic ovf_s2;
  logic ovf_s3;
  logic wr_cc;
  logic wr_sc;
  logic wr_fl;
  logic wr_hi;
  logic wr_lo;
  logic wr_it;
  logic frozen;
  logic tick;
  logic load_now;
  logic reaching_zero;
  logic reload_at_zero;
  logic underflow_set;
  logic acc_overflow_set;
  logic underflow_pending;
  logic acc_overflow_pending;
  logic sample_period_end;
  // Field views of the control registers
  logic underflow_irq_enable;
  logic reload_mode;
  logic read_load_select;
  logic prescale_select;
  logic counter_enable;
  logic acc_overflow_irq_enable;
  logic return_to_zero_enable;
  logic converter_power_up;
  logic wait_mode_disable;
  logic [9:0] prescale_top;
  logic [6:0] sample_top;
  logic [15:0] next_count;
  logic [7:0] next_rdata;

  assign wr_cc = bus.wr && bus.addr == `ADDR_COUNTER_CONTROL;
  assign wr_sc = bus.wr && bus.addr == `ADDR_STALL_DETECT_CONTROL;
  assign wr_fl = bus.wr && bus.addr == `ADDR_FLAGS;
  assign wr_hi = bus.wr && bus.addr == `ADDR_COUNT_HIGH;
  assign wr_lo = bus.wr && bus.addr == `ADDR_COUNT_LOW;
  assign wr_it = bus.wr && bus.addr == `ADDR_INTEGRATE;

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  // Unmapped addresses match no strobe, so those writes vanish
  assign underflow_irq_enable = counter_control[`BIT_UNDERFLOW_IRQ_ENABLE];
  assign reload_mode = counter_control[`BIT_RELOAD_MODE];
  assign read_load_select = counter_control[`BIT_READ_LOAD_SELECT];
  assign prescale_select = counter_control[`BIT_PRESCALER];
  assign counter_enable = counter_control[`BIT_COUNTER_ENABLE];
  assign acc_overflow_irq_enable = counter_control[`BIT_ACC_OVERFLOW_IRQ_ENABLE];
  assign return_to_zero_enable = stall_detect_control[`BIT_RETURN_TO_ZERO_ENABLE];
  assign converter_power_up = stall_detect_control[`BIT_CONVERTER_POWER_UP];
  assign wait_mode_disable = stall_detect_control[`BIT_WAIT_MODE_DISABLE];

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Wait level is asynchronous; only the second stage feeds logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_s1 <= 1'b0;
      wait_s2 <= 1'b0;
    end else begin
      wait_s1 <= wait_mode;
      wait_s2 <= wait_s1;
    end
  end

  // Third stage only remembers the last level for the edge detect
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_s1 <= 1'b0;
      ovf_s2 <= 1'b0;
      ovf_s3 <= 1'b0;
    end else begin
      ovf_s1 <= acc_overflow_event;
      ovf_s2 <= ovf_s1;
      ovf_s3 <= ovf_s2;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Writable at any time, no lock; force-load and spare bits never store
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_control <= `BYTE_ZERO;
    end else if (wr_cc) begin
      counter_control <= bus.wdata & `CC_STORE_MASK;
    end
  end

  // Factory test bit stays zero, so user writes cannot reach test modes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stall_detect_control <= `BYTE_ZERO;
    end else if (wr_sc) begin
      stall_detect_control <= bus.wdata & `SC_STORE_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      integrate_control <= 1'b0;
    end else if (wr_it) begin
      integrate_control <= bus.wdata[`BIT_INTEGRATE_CONTROL];
    end
  end

  // ----------------------------------------
  // Prescalers
  // ----------------------------------------
  assign frozen = wait_s2 && wait_mode_disable;
  assign prescale_top = prescale_active ? `PRESCALE_LONG : `PRESCALE_SHORT;
  assign tick = !frozen && prescale_div == prescale_top;
  assign sample_top = 7'((`SAMPLE_BASE + 7'h01) << sample_rate_active) - 7'h01;
  assign sample_period_end = sample_div == sample_top;

  // A load restarts the divider, so the first tick after it is a full period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale_div <= `DIV_ZERO;
    end else if (load_now || tick) begin
      prescale_div <= `DIV_ZERO;
    end else if (!frozen) begin
      prescale_div <= prescale_div + 10'h001;
    end
  end

  // Select latched only while not integrating; a change mid-run would skew the result
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_rate_active <= 2'b00;
    end else if (!integrate_control) begin
      sample_rate_active <= stall_detect_control[`SAMPLE_SELECT];
    end
  end

  // Wait freeze leaves the sample divider alone; only the counter prescaler stops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_div <= `SAMPLE_ZERO;
    end else if (!integrate_control || sample_period_end) begin
      sample_div <= `SAMPLE_ZERO;
    end else begin
      sample_div <= sample_div + 7'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= integrate_control && sample_period_end;
    end
  end

  // ----------------------------------------
  // Modulus down-counter
  // ----------------------------------------
  assign load_now = (wr_cc && bus.wdata[`BIT_FORCE_LOAD]) ||
    ((wr_hi || wr_lo) && !reload_mode);
  assign reaching_zero = tick && count == `COUNT_ONE;
  // A one-shot counter parked at zero is not a load, so no prescaler swap there
  assign reload_at_zero = tick && count == `COUNT_ZERO && reload_mode;

  always_comb begin
    next_count = count;
    if (!counter_enable) begin
      next_count = `COUNT_PRESET;
    end else if (load_now) begin
      next_count = load_value;
      if (wr_hi) next_count[`HIGH_BYTE] = bus.wdata;
      if (wr_lo) next_count[`LOW_BYTE] = bus.wdata;
    end else if (reload_at_zero) begin
      next_count = load_value;
    end else if (tick && count != `COUNT_ZERO) begin
      next_count = count - `COUNT_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= `COUNT_PRESET;
    end else begin
      count <= next_count;
    end
  end

  // Load register is written in every mode; the counter decides when to take it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_value <= `COUNT_ZERO;
    end else begin
      if (wr_hi) load_value[`HIGH_BYTE] <= bus.wdata;
      if (wr_lo) load_value[`LOW_BYTE] <= bus.wdata;
    end
  end

  // Latched only when the load register really reaches the counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale_active <= 1'b0;
    end else if (counter_enable && (load_now || reload_at_zero)) begin
      prescale_active <= prescale_select;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_tick <= 1'b0;
    end else begin
      counter_tick <= tick;
    end
  end

  // ----------------------------------------
  // Flags and interrupt
  // ----------------------------------------
  // Set wins over a same-cycle clear, so an event is never lost to software
  assign underflow_set = counter_enable && reaching_zero;
  // Edge of the synchronised level; a held overflow raises the flag once
  assign acc_overflow_set = ovf_s2 && !ovf_s3 && integrate_control;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      underflow_flag <= 1'b0;
    end else if (underflow_set) begin
      underflow_flag <= 1'b1;
    end else if (wr_fl && bus.wdata[`BIT_UNDERFLOW_FLAG]) begin
      underflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_overflow_flag <= 1'b0;
    end else if (acc_overflow_set) begin
      acc_overflow_flag <= 1'b1;
    end else if (wr_fl && bus.wdata[`BIT_ACC_OVERFLOW_FLAG]) begin
      acc_overflow_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  assign underflow_pending = underflow_flag && underflow_irq_enable;
  assign acc_overflow_pending = acc_overflow_flag && acc_overflow_irq_enable;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= underflow_pending || acc_overflow_pending;
    end
  end

  // ----------------------------------------
  // Analog and coil control
  // ----------------------------------------
  // The converter needs recovery time after power-up; software must wait it out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      converter_power <= 1'b0;
    end else begin
      converter_power <= converter_power_up && !frozen;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      converter_reset <= 1'b1;
    end else begin
      converter_reset <= !integrate_control;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coil_ctl <= '0;
    end else begin
      coil_ctl.owned <= return_to_zero_enable;
      coil_ctl.recirc_low <= return_to_zero_enable && frozen;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    next_rdata = `BYTE_ZERO;
    unique case (bus.addr)
      `ADDR_COUNTER_CONTROL: next_rdata = counter_control;
      `ADDR_STALL_DETECT_CONTROL: next_rdata = stall_detect_control;
      `ADDR_FLAGS: begin
        next_rdata[`BIT_UNDERFLOW_FLAG] = underflow_flag;
        next_rdata[`BIT_ACC_OVERFLOW_FLAG] = acc_overflow_flag;
      end
      `ADDR_COUNT_HIGH: next_rdata = read_load_select ?
        load_value[`HIGH_BYTE] : count[`HIGH_BYTE];
      `ADDR_COUNT_LOW: next_rdata = read_load_select ?
        load_value[`LOW_BYTE] : count[`LOW_BYTE];
      `ADDR_INTEGRATE: next_rdata[`BIT_INTEGRATE_CONTROL] = integrate_control;
      default: next_rdata = `BYTE_ZERO;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `BYTE_ZERO;
    end else begin
      // Data stands one cycle only; idle zero keeps a shared read bus clean
      rdata <= bus.rd ? next_rdata : `BYTE_ZERO;
    end
  end
endmodule // stall_detector_control
`default_nettype wire

//--- stall_detector_control_monitor.sv
// Port checker for the stall detector control
`timescale 1ns/10ps
`default_nettype none
module stall_detector_control_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire stall_detector_pkg::bus_req_t bus,
  input wire logic [7:0] rdata,
  // Analog and coil side
  input wire logic wait_mode,
  input wire logic acc_overflow_event,
  input wire logic irq,
  input wire logic converter_power,
  input wire logic converter_reset,
  input wire stall_detector_pkg::coil_ctl_t coil_ctl,
  input wire logic counter_tick,
  input wire logic sample_tick,
  input wire logic [1:0] sample_rate_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [9:0] cgap;
  logic [6:0] sgap;
  // --------------------------------
  // Gaps since last tick
  // --------------------------------
  // Saturating, so a freeze only lengthens a gap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cgap <= '1;
    end else begin
      cgap <= counter_tick ? 10'h000 : (cgap == 10'h3FF ? cgap : cgap + 10'h001);
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sgap <= '1;
    end else begin
      sgap <= sample_tick ? 7'h00 : (sgap == 7'h7F ? sgap : sgap + 7'h01);
    end
  end
  property p_owned;
    logic v;
    (bus.wr && bus.addr == 8'h02, v = bus.wdata[7]) |-> ##2 coil_ctl.owned == v;
  endproperty
  // --------------------------------
  // Assertions
  // --------------------------------
  a_rdata_idle: assert property (!bus.rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_ctl_reserved: assert property (bus.rd && bus.addr == 8'h01 |=> rdata[3] == 1'b0 && rdata[1] == 1'b0)
    else $error("force load or spare bit read one");
  a_test_bit_zero: assert property (bus.rd && bus.addr == 8'h02 |=> rdata[4:2] == 3'h0)
    else $error("test or spare bit read one");
  a_unmapped_zero: assert property (bus.rd && bus.addr == 8'h00 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_coil_owned: assert property (p_owned)
    else $error("coil ownership does not follow enable");
  a_recirc_owner: assert property (coil_ctl.recirc_low |-> coil_ctl.owned)
    else $error("recirculation without coil ownership");
  a_frozen_no_tick: assert property (coil_ctl.recirc_low |-> !counter_tick)
    else $error("counter ticked while frozen in wait");
  a_tick_spacing: assert property (counter_tick |-> cgap >= 10'h03F)
    else $error("counter ticks too close");
  a_sample_spacing: assert property (sample_tick |-> sgap >= 7'h07)
    else $error("sample ticks too close");
  a_rate_hold: assert property (!$stable(sample_rate_active) |-> converter_reset || $past(converter_reset))
    else $error("sample rate changed while integrating");
  c_irq: cover property (irq);
  c_recirc: cover property (coil_ctl.recirc_low);
  c_tick: cover property (counter_tick);
endmodule // stall_detector_control_monitor
bind stall_detector_control stall_detector_control_monitor i_stall_detector_control_monitor (
  .clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .wait_mode(wait_mode),
  .acc_overflow_event(acc_overflow_event), .irq(irq), .converter_power(converter_power),
  .converter_reset(converter_reset), .coil_ctl(coil_ctl), .counter_tick(counter_tick),
  .sample_tick(sample_tick), .sample_rate_active(sample_rate_active));
`default_nettype wire

//--- stall_bridge_model.sv
// Behavioural converter and accumulator facing the stall detector
`timescale 1ns/10ps
`default_nettype none
module stall_bridge_model #(
  parameter int OVF_SAMPLES = 16
) (
  // Clock
  input wire logic clk,
  // Detector controls
  input wire logic converter_power,
  input wire logic converter_reset,
  input wire logic sample_tick,
  // Overflow level back to the detector
  output logic acc_overflow_event
);
  int n = 0;
  // Held at zero while in reset or unpowered; freezes once overflowed
  always_ff @(posedge clk) begin
    if (converter_reset || !converter_power) begin
      n <= 0;
    end else if (sample_tick && n < OVF_SAMPLES) begin
      n <= n + 1;
    end
  end
  assign acc_overflow_event = (n == OVF_SAMPLES);
endmodule // stall_bridge_model
`default_nettype wire

//--- stall_detector_control_test.sv
// Self-checking bench for the stall detector control
`timescale 1ns/10ps
`default_nettype none
module stall_detector_control_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wait_mode = 1'b0;
  stall_detector_pkg::bus_req_t bus = '0;
  logic [7:0] rdata;
  logic irq, converter_power, converter_reset, counter_tick, sample_tick, acc_ev;
  stall_detector_pkg::coil_ctl_t coil_ctl;
  logic [1:0] rate;
  int n_errors = 0;
  int checked = 0;
  int c;
  initial begin
    forever #4 clk = ~clk;
  end
  stall_detector_control i_stall_detector_control (.clk(clk), .rst_n(rst_n), .bus(bus),
    .rdata(rdata), .wait_mode(wait_mode), .acc_overflow_event(acc_ev), .irq(irq),
    .converter_power(converter_power), .converter_reset(converter_reset), .coil_ctl(coil_ctl),
    .counter_tick(counter_tick), .sample_tick(sample_tick), .sample_rate_active(rate));
  stall_bridge_model i_stall_bridge_model (.clk(clk), .converter_power(converter_power),
    .converter_reset(converter_reset), .sample_tick(sample_tick), .acc_overflow_event(acc_ev));
  task close_out;
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    chk($sformatf("read %h", a), {8'h00, e}, {8'h00, rdata});
  endtask
  // Bounded wait for irq (0), counter tick (1) or sample tick (2)
  task wait_for(input int w, input int lim);
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
      if (c > lim) begin
        n_errors++;
        $display("MISMATCH wait %0d expected 1 seen 0", w);
        close_out();
      end
    end while (!((w == 0 && irq === 1'b1) || (w == 1 && counter_tick === 1'b1)
      || (w == 2 && sample_tick === 1'b1)));
  endtask
  task per(input int w, input logic [15:0] e);
    wait_for(w, 600);
    wait_for(w, 600);
    chk("tick period", e, c[15:0]);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h01, 8'h00);
    rd(8'h04, 8'hFF);
    chk("converter_reset", 1, converter_reset);
    wr(8'h01, 8'hFF);
    rd(8'h01, 8'hF5);
    wr(8'h02, 8'hFF);
    rd(8'h02, 8'hE3);
    wr(8'h0F, 8'h5A);
    rd(8'h0F, 8'h00);
    chk("owned", 1, coil_ctl.owned);
    @(posedge clk);
    wait_mode <= 1'b1;
    repeat (6) @(posedge clk);
    chk("power", 0, converter_power);
    chk("recirc", 1, coil_ctl.recirc_low);
    wr(8'h02, 8'hC3);
    repeat (4) @(posedge clk);
    chk("power", 1, converter_power);
    chk("recirc", 0, coil_ctl.recirc_low);
    wait_mode <= 1'b0;
    wr(8'h01, 8'h84);
    wr(8'h04, 8'h10);
    wr(8'h05, 8'h00);
    per(1, 16'd64);
    wr(8'h01, 8'h94);
    per(1, 16'd64);
    wr(8'h01, 8'h9C);
    rd(8'h01, 8'h94);
    per(1, 16'd512);
    wr(8'h01, 8'h84);
    wr(8'h04, 8'h00);
    wr(8'h05, 8'h02);
    wait_for(0, 2000);
    rd(8'h03, 8'h80);
    rd(8'h05, 8'h00);
    wr(8'h01, 8'hA4);
    rd(8'h05, 8'h02);
    wr(8'h03, 8'h00);
    rd(8'h03, 8'h80);
    wr(8'h03, 8'h80);
    repeat (3) @(posedge clk);
    chk("irq", 0, irq);
    wr(8'h01, 8'h00);
    wr(8'h01, 8'h40);
    wr(8'h01, 8'h44);
    wr(8'h04, 8'h00);
    wr(8'h05, 8'h03);
    rd(8'h04, 8'hFF);
    wr(8'h01, 8'hCC);
    wait_for(0, 1000);
    wr(8'h03, 8'h80);
    repeat (3) @(posedge clk);
    wait_for(0, 400);
    wr(8'h03, 8'h80);
    wr(8'h01, 8'h01);
    wr(8'h02, 8'h40);
    wr(8'h08, 8'h80);
    repeat (2) @(posedge clk);
    chk("converter_reset", 0, converter_reset);
    per(2, 16'd8);
    wr(8'h02, 8'h43);
    repeat (3) @(posedge clk);
    chk("rate", 0, rate);
    wait_for(0, 400);
    rd(8'h03, 8'h01);
    wr(8'h08, 8'h00);
    repeat (3) @(posedge clk);
    chk("rate", 3, rate);
    chk("converter_reset", 1, converter_reset);
    wr(8'h08, 8'h80);
    per(2, 16'd64);
    close_out();
  end
endmodule // stall_detector_control_test
`default_nettype wire
